/* verilog/scp_regs.sv */
// module: serial control port with sixteen byte registers
`timescale 1ns/1ps
module scpr_regs (
	input  wire logic                                      clk,
	input  wire logic                                      nrst,
	input  wire logic                                      ctrl_serial_clk,
	input  wire logic                                      ctrl_select_n,
	input  wire logic                                      ctrl_serial_in,
	input  wire logic                                      powerdown_reset_n,
	output logic                                           ctrl_serial_out,
	output logic                                           ctrl_serial_out_oe,
	output logic                                           charge_pump_en,
	output logic                                           dsp_reset,
	output logic [scpr_pkg::NUM_REGS*scpr_pkg::DATA_W-1:0] byte_regs_flat
);
	import scpr_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	// settled level: stages two and three agree, else hold
	function automatic logic settle(input logic stage2, input logic stage3, input logic held);
		settle = (stage2 == stage3) ? stage3 : held;
	endfunction : settle

	function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] count);
		count_up = count + CNT_W'(1);
	endfunction : count_up

	// ****************************************
	// input synchronisers
	// ****************************************
	scpr_link_in_t s1_reg, s2_reg, s3_reg;
	logic          pdr1_reg, pdr2_reg, pdr3_reg;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s1_reg   <= 3'b011;
			s2_reg   <= 3'b011;
			s3_reg   <= 3'b011;
			// pin idles high, so no false edge after reset
			pdr1_reg <= 1'b1;
			pdr2_reg <= 1'b1;
			pdr3_reg <= 1'b1;
		end else begin
			s1_reg   <= '{ctrl_serial_clk, ctrl_select_n, ctrl_serial_in};
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			pdr1_reg <= powerdown_reset_n;
			pdr2_reg <= pdr1_reg;
			pdr3_reg <= pdr2_reg;
		end
	end

	// a level counts once stages two and three agree
	logic sclk_reg, sel_n_reg, din_reg, pdr_reg;
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sclk_reg  <= 1'b0;
			sel_n_reg <= 1'b1;
			din_reg   <= 1'b0;
			pdr_reg   <= 1'b1;
		end else begin
			if (s2_reg.clk == s3_reg.clk)
				sclk_reg <= s3_reg.clk;
			if (s2_reg.select_n == s3_reg.select_n)
				sel_n_reg <= s3_reg.select_n;
			if (s2_reg.din == s3_reg.din)
				din_reg <= s3_reg.din;
			if (pdr2_reg == pdr3_reg)
				pdr_reg <= pdr3_reg;
		end
	end

	wire sclk_new = settle(s2_reg.clk, s3_reg.clk, sclk_reg);
	wire sel_new  = settle(s2_reg.select_n, s3_reg.select_n, sel_n_reg);
	wire pdr_new  = settle(pdr2_reg, pdr3_reg, pdr_reg);

	wire active   = !sel_n_reg;
	wire rise     = active && !sclk_reg && sclk_new;
	wire fall     = active && sclk_reg && !sclk_new;
	wire pdr_rise = !pdr_reg && pdr_new;
	wire sel_rise = !sel_n_reg && sel_new;

	// ****************************************
	// frame sequencer
	// ****************************************
	scpr_state_t          state_reg, state_next;
	logic [CNT_W-1:0]     cnt_reg, cnt_next;
	logic [DATA_W-1:0]    shift_reg, shift_next;
	logic [DATA_W-1:0]    tx_reg, tx_next;
	logic [ADDR_W-1:0]    addr_reg, addr_next;
	logic                 rd_reg, rd_next;
	logic [DATA_W-1:0]    regs_reg [NUM_REGS];

	wire                  addr_done = rise && (cnt_reg == CNT_ADDR_DONE - 5'h01);
	wire                  data_done = rise && (cnt_reg == CNT_FRAME_DONE - 5'h01);
	wire [DATA_W-1:0]     shift_in  = {shift_reg[DATA_W-2:0], din_reg};
	wire [ADDR_W-1:0]     addr_in   = shift_in[ADDR_W-1:0];
	wire                  do_write  = data_done && !rd_reg && !sel_new;
	wire                  tx_hold   = (cnt_reg == CNT_ADDR_DONE);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		shift_next = shift_reg;
		tx_next    = tx_reg;
		addr_next  = addr_reg;
		rd_next    = rd_reg;
		case (state_reg)
			SCPR_IDLE: begin
				cnt_next = CNT_RESET;
				if (active) begin
					state_next = SCPR_ADDR;
				end
			end
			SCPR_ADDR: begin
				if (rise) begin
					shift_next = shift_in;
					cnt_next   = count_up(cnt_reg);
				end
				if (addr_done) begin
					addr_next  = addr_in;
					rd_next    = shift_in[RW_BIT];
					tx_next    = regs_reg[addr_in];
					state_next = SCPR_DATA;
				end
			end
			SCPR_DATA: begin
				if (rise) begin
					if (!rd_reg)
						shift_next = shift_in;
					cnt_next = count_up(cnt_reg);
				end
				// top bit stands over the first falling edge of the data half
				if (fall && rd_reg && !tx_hold)
					tx_next = {tx_reg[DATA_W-2:0], 1'b0};
				if (data_done)
					state_next = SCPR_WAIT;
			end
			SCPR_WAIT: begin
				// edges past the sixteenth wait for the enable to rise
				cnt_next = cnt_reg;
			end
			default: begin
				state_next = SCPR_IDLE;
			end
		endcase
		if (sel_rise || !active) begin
			state_next = SCPR_IDLE;
			cnt_next   = CNT_RESET;
			rd_next    = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= SCPR_IDLE;
			cnt_reg   <= CNT_RESET;
			shift_reg <= REG_RESET_VAL;
			tx_reg    <= REG_RESET_VAL;
			addr_reg  <= '0;
			rd_reg    <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			shift_reg <= shift_next;
			tx_reg    <= tx_next;
			addr_reg  <= addr_next;
			rd_reg    <= rd_next;
		end
	end

	// ****************************************
	// byte registers
	// ****************************************
	// power-down edge restores the reference values
	always_ff @(posedge clk) begin
		for (int i = 0; i < NUM_REGS; i++) begin
			if (!nrst || pdr_rise)
				regs_reg[i] <= REG_RESET_VAL;
			else if (do_write && addr_reg == ADDR_W'(i))
				regs_reg[i] <= shift_in;
		end
	end

	// one-cycle restart pulse for the processing core
	always_ff @(posedge clk) begin
		if (!nrst)
			dsp_reset <= 1'b1;
		else
			dsp_reset <= pdr_rise;
	end

	// ****************************************
	// outputs
	// ****************************************
	// flat view of the register file
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++)
			byte_regs_flat[i*DATA_W +: DATA_W] = regs_reg[i];
	end

	assign charge_pump_en     = regs_reg[PUMP_REG_ADDR][PUMP_BIT];
	assign ctrl_serial_out    = tx_reg[DATA_W-1];
	assign ctrl_serial_out_oe = (state_reg == SCPR_DATA) && rd_reg;
endmodule : scpr_regs

/* pkg/scp_pkg.sv */
// package: constants and types for the serial control port register block
package scpr_pkg;
	localparam int         NUM_REGS       = 16;
	localparam int         ADDR_W         = 4;
	localparam int         DATA_W         = 8;
	localparam int         FRAME_BITS     = 16;
	localparam int         CNT_W          = 5;
	localparam logic [7:0] REG_RESET_VAL  = 8'h00;
	localparam logic [3:0] PUMP_REG_ADDR  = 4'h0;
	localparam int         PUMP_BIT       = 0;
	localparam logic [4:0] CNT_RESET      = 5'h00;
	localparam logic [4:0] CNT_ADDR_DONE  = 5'h08;
	localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
	localparam int         RW_BIT         = 7;

	typedef struct packed {
		logic clk;
		logic select_n;
		logic din;
	} scpr_link_in_t;

	typedef enum logic [1:0] {
		SCPR_IDLE = 2'b00,
		SCPR_ADDR = 2'b01,
		SCPR_DATA = 2'b11,
		SCPR_WAIT = 2'b10
	} scpr_state_t;
endpackage : scpr_pkg

/* testbench/scp_regs_sva.sv */
// checker: port assertions of the control port
`timescale 1ns/1ps
module scpr_regs_sva
	import scpr_pkg::*;
(
	input wire logic                       clk,
	input wire logic                       nrst,
	input wire logic                       ctrl_select_n,
	input wire logic                       powerdown_reset_n,
	input wire logic                       ctrl_serial_out_oe,
	input wire logic                       charge_pump_en,
	input wire logic                       dsp_reset,
	input wire logic [NUM_REGS*DATA_W-1:0] byte_regs_flat
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence quiet8; (ctrl_select_n && powerdown_reset_n)[*8]; endsequence
	sequence pd_rise; $rose(powerdown_reset_n); endsequence
	chk_regs_idle: assert property (quiet8 |=> $stable(byte_regs_flat))
		else $error("registers changed while idle");
	chk_oe_idle: assert property (ctrl_select_n[*8] |-> !ctrl_serial_out_oe)
		else $error("output enabled while deselected");
	chk_oe_framed: assert property ($rose(ctrl_serial_out_oe) |-> !ctrl_select_n)
		else $error("output enabled outside frame");
	chk_pump_reg: assert property ($stable(byte_regs_flat[0])[*2] |->
		charge_pump_en == byte_regs_flat[0]) else $error("pump differs from register");
	chk_pd_clear: assert property (pd_rise |-> ##[1:6] byte_regs_flat == '0)
		else $error("registers not cleared");
	chk_dsp_pulse: assert property (pd_rise |-> ##[1:6] dsp_reset)
		else $error("no reset pulse");
	chk_dsp_once: assert property (dsp_reset && $past(nrst) |=> !dsp_reset)
		else $error("reset pulse too long");
	chk_rst_vals: assert property (disable iff (1'b0) !nrst |=>
		byte_regs_flat == '0 && dsp_reset && !ctrl_serial_out_oe) else $error("bad reset");
endmodule : scpr_regs_sva
bind scpr_regs scpr_regs_sva chk (.clk, .nrst, .ctrl_select_n, .powerdown_reset_n,
	.ctrl_serial_out_oe, .charge_pump_en, .dsp_reset, .byte_regs_flat);

/* testbench/scp_ctrl_model.sv */
// partner: serial control master
`timescale 1ns/1ps
module scpr_ctrl_model (
	output logic      sclk,
	output logic      sel_n,
	output logic      sdo,
	input  wire logic sdi
);
	initial begin
		sclk = 1'b0;
		sel_n = 1'b1;
		sdo = 1'b0;
	end
	task automatic frame(input logic [15:0] w, input int nb, input bit gap,
		output logic [7:0] r);
		#1.3 sel_n = 1'b0;
		for (int i = 15; i > 15 - nb; i--) begin
			sdo = w[i];
			#62.5 sclk = 1'b1;
			r = {r[6:0], sdi};
			#62.5 sclk = 1'b0;
			if (gap && i == 8) #300;
		end
		#62.5 sel_n = 1'b1;
		sdo = ~sdo;
		#201.2;
	endtask : frame
	task automatic burst(input int n);
		#1.3;
		repeat (n) begin
			#62.5 sclk = ~sclk;
			sdo = ~sdo;
		end
	endtask : burst
endmodule : scpr_ctrl_model

/* testbench/scp_regs_tb.sv */
// testbench: self-checking bench of the control port
`timescale 1ns/1ps
module serial_control_port_regs_tb;
	import scpr_pkg::*;
	logic clk, nrst, pd_n, sclk, sel_n, sdo, sout, oe, pump, dsp_rst;
	logic [NUM_REGS*DATA_W-1:0] regs;
	logic [7:0]                 exp_q[$], seen, e, r, m[16];
	string                      what;
	int                         fail_count, checks_done;
	event                       got;
	scpr_regs dut (.clk, .nrst, .ctrl_serial_clk(sclk), .ctrl_select_n(sel_n),
		.ctrl_serial_in(sdo), .powerdown_reset_n(pd_n), .ctrl_serial_out(sout),
		.ctrl_serial_out_oe(oe), .charge_pump_en(pump), .dsp_reset(dsp_rst), .byte_regs_flat(regs));
	// released transmit line shows the inverse of the last bit
	scpr_ctrl_model ctrl (.sclk, .sel_n, .sdo, .sdi(oe ? sout : ~sout));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic look(input string n, input logic [7:0] v);
		what = n;
		seen = v;
		-> got;
		@(posedge clk);
	endtask : look
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : conclude
	always @(got) begin
		checks_done++;
		e = exp_q.pop_front();
		if (e !== seen) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, e, seen);
		end
	end
	initial begin
		nrst = 1'b0;
		pd_n = 1'b1;
		void'($urandom(40489));
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		exp_q.push_back(8'h00);
		look("reset reg", regs[47:40]);
		$display("reset check done");
		for (int i = 0; i < 16; i++) begin
			m[i] = 8'($urandom);
			ctrl.frame({1'b0, 3'($urandom), 4'(i), m[i]}, 16, i[0], r);
		end
		for (int i = 0; i < 16; i++) begin
			exp_q.push_back(m[i]);
			ctrl.frame({1'b1, 3'($urandom), 4'(i), 8'($urandom)}, 16, i[1], r);
			look("read", r);
			exp_q.push_back(m[i]);
			look("reg", regs[i*8+:8]);
		end
		exp_q.push_back({7'h00, m[0][0]});
		look("pump", {7'h00, pump});
		$display("write and read done");
		ctrl.frame({8'h03, ~m[3]}, 15, 1'b0, r);
		ctrl.burst(40);
		exp_q.push_back(m[3]);
		look("aborted reg", regs[31:24]);
		$display("abort done");
		pd_n <= 1'b0;
		repeat (4) @(posedge clk);
		pd_n <= 1'b1;
		repeat (10) @(posedge clk);
		exp_q.push_back(8'h00);
		look("powerdown", regs[31:24] | {7'h00, pump});
		$display("powerdown done");
		conclude();
	end
	initial begin
		#500us;
		fail_count++;
		conclude();
	end
endmodule : serial_control_port_regs_tb
